// ### hw/ees_i2c_eeprom.sv
// Two-wire serial slave giving access to a 256-byte non-volatile array
`timescale 1ns/1ps
module ees_i2c_eeprom #(
	parameter int PROG_CYCLES = ees_pkg::PROG_CYCLES,
	parameter logic [6:0] DEV_ADDR = ees_pkg::MEM_DEV_ADDR
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic write_protect_n,
	output logic prog_busy
);
	// Pin synchronisers, two flops each, plus a delayed copy for edges
	logic [1:0] scl_sync_reg, sda_sync_reg, wp_sync_reg;
	logic scl_d_reg, sda_d_reg;
	logic scl_s, sda_s;
	logic scl_rise, scl_fall, start_cond, stop_cond;

	// Link state
	ees_pkg::ees_state_t state_reg, state_next;
	logic [ees_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [ees_pkg::BYTE_W-1:0] shift_reg, shift_next;
	logic [ees_pkg::BYTE_W-1:0] tx_reg, tx_next;
	logic rw_reg, rw_next;
	logic oe_reg, oe_next;
	logic rd_adv;

	// Address counter, page buffer, commit and programming timer
	logic [ees_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [ees_pkg::BYTE_W-1:0] page_reg [ees_pkg::PAGE_WORDS];
	logic [ees_pkg::BYTE_W-1:0] page_next [ees_pkg::PAGE_WORDS];
	logic [ees_pkg::PAGE_WORDS-1:0] vld_reg, vld_next;
	logic pend_reg, pend_next;
	logic commit_reg, commit_next;
	logic [ees_pkg::PAGE_W-1:0] cidx_reg, cidx_next;
	logic [ees_pkg::PAGE_W-1:0] chi_reg, chi_next;
	logic [ees_pkg::PROG_CNT_W-1:0] prog_cnt_reg, prog_cnt_next;
	logic busy_reg, busy_next;

	// Memory array in flip-flops
	logic [ees_pkg::BYTE_W-1:0] mem_reg [ees_pkg::MEM_WORDS];
	logic mem_we;
	logic [ees_pkg::ADDR_W-1:0] mem_waddr;

	// Received bytes pass a two-entry buffer before being applied
	ees_stream_if #(.WIDTH(ees_pkg::ENT_W)) rx_in ();
	ees_stream_if #(.WIDTH(ees_pkg::ENT_W)) rx_out ();
	logic pop_addr, pop_data;

	ees_skid_buf #(
		.WIDTH(ees_pkg::ENT_W),
		.DEPTH(ees_pkg::BUF_DEPTH)
	) u_rx_buf (
		.clk(ref_clk),
		.rst(rst),
		.in_s(rx_in),
		.out_s(rx_out)
	);

	// Line events on synchronised copies; first stage feeds only second
	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			wp_sync_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			wp_sync_reg <= {wp_sync_reg[0], write_protect_n};
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Link state machine: receive on clock rise, drive on clock fall
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		rw_next = rw_reg;
		oe_next = oe_reg;
		rd_adv = 1'b0;
		rx_in.valid = 1'b0;
		rx_in.data = '0;
		if (stop_cond)
		begin
			state_next = ees_pkg::ST_IDLE;
			oe_next = 1'b0;
		end
		else if (start_cond)
		begin
			// Repeated start is taken the same way, used for random read
			state_next = ees_pkg::ST_DEVADDR;
			cnt_next = '0;
			oe_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				ees_pkg::ST_DEVADDR, ees_pkg::ST_WORDADDR, ees_pkg::ST_WDATA:
				begin
					// Data is sampled only while clock is high
					if (scl_rise)
					begin
						shift_next = {shift_reg[6:0], sda_s};
						cnt_next = cnt_reg + 1'b1;
					end
					else if (scl_fall && cnt_reg == ees_pkg::CNT_BYTE)
					begin
						cnt_next = '0;
						if (state_reg == ees_pkg::ST_DEVADDR)
						begin
							// Busy array ignores its address entirely
							if (shift_reg[7:1] == DEV_ADDR && !busy_reg && !commit_reg)
							begin
								rw_next = shift_reg[ees_pkg::RW_BIT];
								oe_next = 1'b1;
								state_next = ees_pkg::ST_DEV_ACK;
							end
							else
								state_next = ees_pkg::ST_WAIT_STOP;
						end
						else
						begin
							// No room means no ack, so no byte is lost silently
							rx_in.valid = 1'b1;
							rx_in.data = {state_reg == ees_pkg::ST_WORDADDR, shift_reg};
							if (rx_in.ready)
							begin
								oe_next = 1'b1;
								state_next = (state_reg == ees_pkg::ST_WORDADDR) ?
									ees_pkg::ST_WA_ACK : ees_pkg::ST_WD_ACK;
							end
							else
								state_next = ees_pkg::ST_WAIT_STOP;
						end
					end
				end
				ees_pkg::ST_DEV_ACK:
				begin
					if (scl_fall)
					begin
						if (rw_reg)
						begin
							tx_next = mem_reg[addr_reg];
							oe_next = ~mem_reg[addr_reg][7];
							rd_adv = 1'b1;
							state_next = ees_pkg::ST_RDATA;
						end
						else
						begin
							oe_next = 1'b0;
							state_next = ees_pkg::ST_WORDADDR;
						end
					end
				end
				ees_pkg::ST_WA_ACK, ees_pkg::ST_WD_ACK:
				begin
					// Further bytes in the same frame are page data
					if (scl_fall)
					begin
						oe_next = 1'b0;
						state_next = ees_pkg::ST_WDATA;
					end
				end
				ees_pkg::ST_RDATA:
				begin
					if (scl_fall)
					begin
						cnt_next = cnt_reg + 1'b1;
						if (cnt_reg == ees_pkg::CNT_LAST)
						begin
							oe_next = 1'b0;
							cnt_next = '0;
							state_next = ees_pkg::ST_RD_ACK;
						end
						else
						begin
							tx_next = {tx_reg[6:0], 1'b0};
							oe_next = ~tx_reg[6];
						end
					end
				end
				ees_pkg::ST_RD_ACK:
				begin
					// Master's answer sampled at the ninth clock high
					if (scl_rise)
						shift_next[0] = sda_s;
					else if (scl_fall)
					begin
						if (!shift_reg[0])
						begin
							tx_next = mem_reg[addr_reg];
							oe_next = ~mem_reg[addr_reg][7];
							rd_adv = 1'b1;
							state_next = ees_pkg::ST_RDATA;
						end
						else
							state_next = ees_pkg::ST_WAIT_STOP;
					end
				end
				ees_pkg::ST_IDLE, ees_pkg::ST_WAIT_STOP:
					oe_next = 1'b0;
				default:
				begin
					state_next = ees_pkg::ST_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg <= ees_pkg::ST_IDLE;
			cnt_reg <= '0;
			shift_reg <= '0;
			tx_reg <= '0;
			rw_reg <= 1'b0;
			oe_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			rw_reg <= rw_next;
			oe_reg <= oe_next;
		end
	end

	// Buffer drain stalls while a page is copied into the array
	assign rx_out.ready = ~commit_reg;
	assign pop_addr = rx_out.valid & ~commit_reg & rx_out.data[ees_pkg::ENT_ADDR_BIT];
	assign pop_data = rx_out.valid & ~commit_reg & ~rx_out.data[ees_pkg::ENT_ADDR_BIT];

	// Address counter, page collection, commit and programming timer
	always_comb
	begin
		addr_next = addr_reg;
		page_next = page_reg;
		vld_next = vld_reg;
		pend_next = pend_reg;
		commit_next = commit_reg;
		cidx_next = cidx_reg;
		chi_next = chi_reg;
		prog_cnt_next = prog_cnt_reg;
		busy_next = busy_reg;
		mem_we = 1'b0;
		mem_waddr = {chi_reg, cidx_reg};
		if (pop_addr)
		begin
			addr_next = rx_out.data[ees_pkg::BYTE_W-1:0];
			vld_next = '0;
		end
		else if (pop_data)
		begin
			page_next[addr_reg[ees_pkg::PAGE_W-1:0]] = rx_out.data[ees_pkg::BYTE_W-1:0];
			vld_next[addr_reg[ees_pkg::PAGE_W-1:0]] = 1'b1;
			// Low nibble only; wraps within the page
			addr_next[ees_pkg::PAGE_W-1:0] = addr_reg[ees_pkg::PAGE_W-1:0] + 1'b1;
			pend_next = 1'b1;
		end
		else if (rd_adv)
			addr_next = addr_reg + 1'b1;
		if (stop_cond && pend_reg)
		begin
			pend_next = 1'b0;
			// Protected: drop the page, counter stays where the writes left it
			if (!wp_sync_reg[1])
			begin
				commit_next = 1'b1;
				cidx_next = '0;
				chi_next = addr_reg[ees_pkg::ADDR_W-1:ees_pkg::PAGE_W];
			end
		end
		if (commit_reg)
		begin
			mem_we = vld_reg[cidx_reg];
			cidx_next = cidx_reg + 1'b1;
			if (cidx_reg == ees_pkg::PAGE_W'(ees_pkg::PAGE_WORDS - 1))
			begin
				commit_next = 1'b0;
				busy_next = 1'b1;
				prog_cnt_next = ees_pkg::PROG_CNT_W'(PROG_CYCLES);
			end
		end
		else if (busy_reg)
		begin
			prog_cnt_next = prog_cnt_reg - 1'b1;
			if (prog_cnt_reg <= ees_pkg::PROG_CNT_W'(1))
				busy_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			addr_reg <= ees_pkg::ADDR_RST;
			vld_reg <= '0;
			pend_reg <= 1'b0;
			commit_reg <= 1'b0;
			cidx_reg <= '0;
			chi_reg <= '0;
			prog_cnt_reg <= '0;
			busy_reg <= 1'b0;
		end
		else
		begin
			addr_reg <= addr_next;
			vld_reg <= vld_next;
			pend_reg <= pend_next;
			commit_reg <= commit_next;
			cidx_reg <= cidx_next;
			chi_reg <= chi_next;
			prog_cnt_reg <= prog_cnt_next;
			busy_reg <= busy_next;
		end
	end

	// Page buffer entries, one flop group per slot
	genvar gi;
	generate
		for (gi = 0; gi < ees_pkg::PAGE_WORDS; gi++)
		begin : g_page
			always_ff @(posedge ref_clk)
			begin
				if (rst)
					page_reg[gi] <= '0;
				else
					page_reg[gi] <= page_next[gi];
			end
		end
	endgenerate

	// Array write port; contents model the erased state after reset
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < ees_pkg::MEM_WORDS; i++)
				mem_reg[i] <= ees_pkg::MEM_RST;
		end
		else if (mem_we)
			mem_reg[mem_waddr] <= page_reg[cidx_reg];
	end

	// Registered pin drivers; open drain so the level is always low
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			prog_busy <= 1'b0;
		end
		else
		begin
			sda_out <= 1'b0;
			sda_oe <= oe_reg;
			prog_busy <= busy_reg | commit_reg;
		end
	end
endmodule // ees_i2c_eeprom

// ### hw/ees_skid_buf.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ees_skid_buf #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	ees_stream_if.snk in_s,
	ees_stream_if.src out_s
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [PW:0] cnt_reg, cnt_next;
	logic push, pop;

	// Honest flags: full refuses, empty shows no valid
	assign in_s.ready = (cnt_reg != (PW + 1)'(DEPTH));
	assign out_s.valid = (cnt_reg != '0);
	assign out_s.data = mem_reg[rptr_reg];
	assign push = in_s.valid & in_s.ready;
	assign pop = out_s.valid & out_s.ready;

	// Pointer and count update
	always_comb
	begin
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		cnt_next = cnt_reg;
		if (push)
			wptr_next = (wptr_reg == PW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
		if (pop)
			rptr_next = (rptr_reg == PW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
		if (push && !pop)
			cnt_next = cnt_reg + 1'b1;
		else if (pop && !push)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage needs no reset; count guards it
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wptr_reg] <= in_s.data;
	end
endmodule // ees_skid_buf

// ### pkg/ees_pkg.sv
// Shared constants and state codes for the serial EEPROM slave block
package ees_pkg;
	// Memory geometry
	localparam int MEM_WORDS = 256;
	localparam int ADDR_W = 8;
	localparam int BYTE_W = 8;
	localparam int PAGE_WORDS = 16;
	localparam int PAGE_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
	localparam logic [BYTE_W-1:0] MEM_RST = 8'hff;
	// Memory slave address, upper bit fixed at zero; low bits arbitrary
	localparam logic [6:0] MEM_DEV_ADDR = 7'h2a;
	// Position of the read/write bit in the slave address byte
	localparam int RW_BIT = 0;
	// Bit counter width and value at a completed byte
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_BYTE = 4'h8;
	localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;
	// Buffer entry: flag bit above one byte
	localparam int ENT_W = 9;
	localparam int ENT_ADDR_BIT = 8;
	localparam int BUF_DEPTH = 2;
	// Programming cycle timing
	localparam int CLK_MHZ = 125;
	localparam int PROG_TIME_US = 1000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int PROG_CNT_W = 24;
	// Link state machine, one-hot
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_DEVADDR = 10'h002,
		ST_DEV_ACK = 10'h004,
		ST_WORDADDR = 10'h008,
		ST_WA_ACK = 10'h010,
		ST_WDATA = 10'h020,
		ST_WD_ACK = 10'h040,
		ST_RDATA = 10'h080,
		ST_RD_ACK = 10'h100,
		ST_WAIT_STOP = 10'h200
	} ees_state_t;
endpackage

// ### pkg/ees_stream_if.sv
// Valid/ready stream carrier between the link logic and its buffer
`timescale 1ns/1ps
interface ees_stream_if #(
	parameter int WIDTH = 9
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### test/ees_i2c_eeprom_checker.sv
// Pin-level assertions for the serial EEPROM slave
`timescale 1ns/1ps
module ees_i2c_eeprom_checker #(
	parameter int PROG_CYCLES = 50
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic write_protect_n,
	input wire logic prog_busy
);
	int busy_cnt_reg;
	int busy_cnt_next;
	logic [3:0] since_stop_reg;
	logic [3:0] since_stop_next;
	logic sda_d_reg;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Busy run length and cycles since a stop, saturating
	always_comb
	begin
		busy_cnt_next = prog_busy ? busy_cnt_reg + 1 : 0;
		since_stop_next = since_stop_reg;
		if (scl_in && sda_in && !sda_d_reg)
			since_stop_next = 4'h0;
		else if (since_stop_reg != 4'hf)
			since_stop_next = since_stop_reg + 4'h1;
	end
	// Helper registers only
	always_ff @(posedge ref_clk)
	begin
		busy_cnt_reg <= rst ? 0 : busy_cnt_next;
		since_stop_reg <= rst ? 4'hf : since_stop_next;
		sda_d_reg <= sda_in;
	end
	sequence hold_s;
		sda_oe [*8];
	endsequence
	chk_ack_hold: assert property ($rose(sda_oe) |-> hold_s)
		else $error("data pull released too early");
	chk_oe_clk_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
		else $error("data pulled while clock high");
	chk_oe_clk_high: assert property ($rose(scl_in) |=> $stable(sda_oe) [*8])
		else $error("data moved while clock high");
	chk_out_low: assert property (sda_oe |-> !sda_out)
		else $error("open drain value not low");
	chk_busy_quiet: assert property (prog_busy |-> !sda_oe)
		else $error("bus answered while programming");
	chk_busy_len: assert property ($fell(prog_busy) |->
		busy_cnt_reg >= PROG_CYCLES + 15 && busy_cnt_reg <= PROG_CYCLES + 17)
		else $error("programming time wrong");
	chk_busy_stop: assert property ($rose(prog_busy) |-> since_stop_reg <= 4'hc)
		else $error("programming began without a stop");
	chk_wp_block: assert property ($rose(prog_busy) |-> !$past(write_protect_n, 4))
		else $error("programming while protected");
	chk_start_free: assert property (scl_in && $fell(sda_in) |-> ##5 !sda_oe)
		else $error("data held after start");
endmodule // ees_i2c_eeprom_checker

bind ees_i2c_eeprom ees_i2c_eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
	.ref_clk(ref_clk),
	.rst(rst),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.write_protect_n(write_protect_n),
	.prog_busy(prog_busy)
);

// ### test/ees_i2c_eeprom_test.sv
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/1ps
module ees_i2c_eeprom_test;
	localparam int PROG = 300;
	localparam logic [6:0] DEV = ees_pkg::MEM_DEV_ADDR;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic write_protect_n = 1'b0;
	logic scl;
	logic m_oe;
	logic sda_oe;
	logic prog_busy;
	logic sda_out;
	logic [8:0] res;
	logic res_stb;
	// Open drain: released line floats high through the pull-up
	wire sda_w = !m_oe & (sda_oe ? sda_out : 1'b1);
	logic [8:0] exp_q[$];
	logic [7:0] mem[256];
	logic [7:0] base;
	logic [7:0] d;
	int fails = 0;
	int check_count = 0;
	always #4 ref_clk = ~ref_clk;
	ees_i2c_eeprom #(.PROG_CYCLES(PROG)) dut_u (
		.ref_clk(ref_clk),
		.rst(rst),
		.scl_in(scl),
		.sda_in(sda_w),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.write_protect_n(write_protect_n),
		.prog_busy(prog_busy)
	);
	ees_i2c_master m_u (
		.sda_w(sda_w),
		.scl(scl),
		.sda_m_oe(m_oe),
		.res(res),
		.res_stb(res_stb)
	);
	task automatic check(input string n, input logic [8:0] seen, input logic [8:0] e);
	begin
		check_count++;
		if (seen !== e)
		begin
			fails++;
			$display("unexpected %s exp %h seen %h", n, e, seen);
		end
	end
	endtask
	task automatic test_done();
	begin
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	// Each finished byte is matched with the oldest note
	always @(posedge res_stb)
	begin
		check("byte", res, exp_q.pop_front());
	end
	// Note the expected ack and byte, then run it
	task automatic xb(input logic [7:0] v, input int mode, input logic [8:0] e);
	begin
		exp_q.push_back(e);
		m_u.xfer(v, mode);
	end
	endtask
	task automatic wr(input logic [7:0] v);
	begin
		xb(v, 0, {1'b1, v});
	end
	endtask
	task automatic rd(input logic [7:0] e, input int mode);
	begin
		xb(8'hff, mode, {mode == 1, e});
	end
	endtask
	task automatic sa(input logic [6:0] a, input logic rw, input logic ack);
	begin
		m_u.start();
		xb({a, rw}, 0, {ack, a, rw});
	end
	endtask
	task automatic seta(input logic [7:0] a);
	begin
		sa(DEV, 1'b0, 1'b1);
		wr(a);
	end
	endtask
	task automatic wait_busy(input logic v);
		int n;
	begin
		n = 0;
		while (prog_busy !== v && n < 2000)
		begin
			@(posedge ref_clk);
			n++;
		end
		check("busy", 9'(prog_busy), 9'(v));
		if (n >= 2000)
			test_done();
	end
	endtask
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'hff;
		void'($urandom(55045));
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		// Byte write, then address refused while programming
		seta(8'h5c);
		wr(8'h3c);
		m_u.stop();
		mem[8'h5c] = 8'h3c;
		wait_busy(1'b1);
		sa(DEV, 1'b0, 1'b0);
		m_u.stop();
		wait_busy(1'b0);
		// Random read of the byte just stored
		seta(8'h5c);
		sa(DEV, 1'b1, 1'b1);
		rd(8'h3c, 2);
		m_u.stop();
		// Page write past sixteen bytes on a slow clock
		base = 8'($urandom());
		m_u.q = 80ns;
		seta(base);
		for (int i = 0; i < 18; i++)
		begin
			d = 8'($urandom());
			mem[{base[7:4], base[3:0] + 4'(i)}] = d;
			wr(d);
		end
		m_u.stop();
		m_u.q = 40ns;
		wait_busy(1'b1);
		wait_busy(1'b0);
		// Current address read continues as a sequential read
		base[3:0] = base[3:0] + 4'h2;
		sa(DEV, 1'b1, 1'b1);
		for (int i = 0; i < 17; i++)
			rd(mem[base + 8'(i)], i < 16 ? 1 : 2);
		m_u.stop();
		// Sequential read across the top location
		seta(8'hfe);
		sa(DEV, 1'b1, 1'b1);
		for (int i = 0; i < 4; i++)
			rd(mem[8'hfe + 8'(i)], i < 3 ? 1 : 0);
		m_u.stop();
		// Protected write is acked but leaves memory alone
		@(posedge ref_clk);
		write_protect_n <= 1'b1;
		seta(8'h5c);
		wr(8'ha5);
		m_u.stop();
		repeat (40) @(posedge ref_clk);
		check("busy", 9'(prog_busy), 9'h000);
		write_protect_n <= 1'b0;
		seta(8'h5c);
		sa(DEV, 1'b1, 1'b1);
		rd(mem[8'h5c], 2);
		m_u.stop();
		// Another slave address is not answered
		sa(DEV ^ 7'h40, 1'b0, 1'b0);
		m_u.stop();
		check("left", 9'(exp_q.size()), 9'h000);
		test_done();
	end
endmodule // ees_i2c_eeprom_test

// ### test/ees_i2c_master.sv
// Behavioural two-wire bus master for the EEPROM bench
`timescale 1ns/1ps
module ees_i2c_master (
	input wire logic sda_w,
	output logic scl,
	output logic sda_m_oe,
	output logic [8:0] res,
	output logic res_stb
);
	time q = 40ns;
	// Idle bus: both lines released high
	initial
	begin
		scl = 1'b1;
		sda_m_oe = 1'b0;
		res = 9'h000;
		res_stb = 1'b0;
	end
	// Start or repeated start, entered mid low phase
	task automatic start();
	begin
		sda_m_oe <= 1'b0;
		#q scl <= 1'b1;
		#q sda_m_oe <= 1'b1;
		#q scl <= 1'b0;
		#q;
	end
	endtask
	// Stop, then idle; odd gap drifts the phase against ref_clk
	task automatic stop();
	begin
		sda_m_oe <= 1'b1;
		#q scl <= 1'b1;
		#q sda_m_oe <= 1'b0;
		#(4 * q + 3ns);
	end
	endtask
	// One bit: change in low phase, sample mid high
	task automatic bit_x(input logic b, output logic s);
	begin
		sda_m_oe <= !b;
		#q scl <= 1'b1;
		#q s = sda_w;
		#q scl <= 1'b0;
		#q;
	end
	endtask
	// Mode 0 slave acks, 1 master acks, 2 no ninth clock
	task automatic xfer(input logic [7:0] d, input int mode);
		logic [8:0] r;
		logic s;
	begin
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(d[i], s);
			r[i] = s;
		end
		r[8] = 1'b0;
		if (mode != 2)
		begin
			bit_x(mode == 0, s);
			r[8] = !s;
		end
		res <= r;
		res_stb <= 1'b1;
		#1 res_stb <= 1'b0;
	end
	endtask
endmodule // ees_i2c_master
